// file: sbr_pkg.sv
// Purpose: Shared constants for the serial baud and receiver timing block
// Assumes: AHB-Lite register access, 32-bit words, 10 MHz clock
// Notes: Offsets are byte addresses
package sbr_pkg;
	// Register byte offsets
	localparam logic [7:0] SBR_OFS_RATE = 8'h00;
	localparam logic [7:0] SBR_OFS_CTRL = 8'h04;
	localparam logic [7:0] SBR_OFS_STAT = 8'h08;
	localparam logic [7:0] SBR_OFS_MASK = 8'h0C;
	localparam logic [7:0] SBR_OFS_DATA = 8'h10;
	// Rate register fields
	localparam int SBR_PS_LSB = 3;
	localparam int SBR_RS_LSB = 0;
	localparam logic [7:0] SBR_RATE_RST = 8'h00;
	// Control register fields
	localparam int SBR_CTL_STANDBY = 0;
	localparam int SBR_CTL_WAKE = 1;
	localparam int SBR_CTL_NINE = 2;
	localparam int SBR_CTL_RXEN = 3;
	// Status / mask fields
	localparam int SBR_ST_RXDONE = 0;
	localparam int SBR_ST_FRAME = 1;
	localparam int SBR_ST_WOKE = 2;
	localparam int SBR_ST_W = 3;
	// Timing
	localparam int SBR_BASE_DIV = 64;
	localparam int SBR_TICKS_PER_BIT = 16;
	localparam int SBR_TICK_DIV = SBR_BASE_DIV / SBR_TICKS_PER_BIT;
	localparam logic [3:0] SBR_SMP_A = 4'h7;
	localparam logic [3:0] SBR_SMP_B = 4'h8;
	localparam logic [3:0] SBR_SMP_C = 4'h9;
	localparam logic [3:0] SBR_BIT_LAST = 4'hF;
	localparam int SBR_IDLE_BITS = 10;
	// Prescaler divisors
	localparam logic [3:0] SBR_PD0 = 4'h1;
	localparam logic [3:0] SBR_PD1 = 4'h3;
	localparam logic [3:0] SBR_PD2 = 4'h4;
	localparam logic [3:0] SBR_PD3 = 4'hD;
	// AHB transfer type
	localparam logic [1:0] SBR_HTRANS_NONSEQ = 2'h2;
endpackage

// file: sbr_core.sv
// Purpose: Baud generator and receiver timing with standby for a serial port
// Assumes: AHB-Lite single word transfers, one clock MCLK, SRST synchronous
// Notes: Outputs registered, zero wait states; a start needs a high-to-low line edge
// Operation
// - Baud rate equals clock over 64 times prescale times rate divisor.
// - Bus clock MCLK is the baud generator clock source.
// - Prescaler codes 00,01,10,11 give divisors 1,3,4,13.
// - Rate select code n gives divisor two to the n.
// - Reset clears prescaler and rate select fields.
// - One rate setting drives both transmitter and receiver.
// - Sixteen ticks per bit; stop bit sampled at ticks 8, 9, 10.
// - Eight-bit character stop sampling ends 9 bits plus 10 ticks after start.
// - Nine-bit character stop sampling ends 10 bits plus 10 ticks after start.
// - Standby request suppresses all receiver interrupt requests except the wake flag.
// - Wake select bit chooses which line condition ends standby.
`timescale 1ns/100ps
module sbr_core
	import sbr_pkg::*;
#(
	parameter int DATA_W = 9
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HSEL,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic RXD,
	output logic TX_BIT_TICK,
	output logic RX_SAMPLE_TICK,
	output logic IRQ
);
	typedef enum logic [1:0] {
		SBR_IDLE = 2'b00,
		SBR_START = 2'b01,
		SBR_DATA = 2'b10,
		SBR_STOP = 2'b11
	} sbr_state_e;

	// Prescale divisor lookup
	function automatic logic [3:0] sbr_pd(input logic [1:0] code);
		case (code)
			2'b00: sbr_pd = SBR_PD0;
			2'b01: sbr_pd = SBR_PD1;
			2'b10: sbr_pd = SBR_PD2;
			default: sbr_pd = SBR_PD3;
		endcase
	endfunction

	// Two-flop synchroniser on the line
	logic rxd_m_q, rxd_s_q;
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
		end else begin
			rxd_m_q <= RXD;
			rxd_s_q <= rxd_m_q;
		end
	end

	// Register state
	logic [7:0] rate_q, rate_d;
	logic [3:0] ctrl_q, ctrl_d;
	logic [SBR_ST_W-1:0] stat_q, stat_d, mask_q, mask_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic aph_wr_q, aph_wr_d, aph_rd_q, aph_rd_d;
	logic [7:0] aph_addr_q, aph_addr_d;
	logic irq_q, irq_d;
	// Divider and receiver state
	logic [3:0] pre_q, pre_d;
	logic [1:0] quad_q, quad_d;
	logic [6:0] rdiv_q, rdiv_d;
	logic tick_q, tick_d, bit_q, bit_d;
	logic [3:0] tkbit_q, tkbit_d;
	logic [3:0] ntick_q, ntick_d;
	sbr_state_e st_q, st_d;
	logic [3:0] bitn_q, bitn_d;
	logic [DATA_W-1:0] shf_q, shf_d;
	logic [2:0] smp_q, smp_d;
	logic [4:0] idle_q, idle_d;
	logic line_hi_q, line_hi_d;

	logic [3:0] pd_last;
	logic [6:0] bd_last;
	logic [1:0] ps_code;
	logic [2:0] rs_code;
	logic nine;
	logic ev_done, ev_frame, ev_woke;

	// Baud chain from MCLK: prescale, fixed 4, then power-of-two, giving 16x ticks
	always_comb begin
		ps_code = rate_q[SBR_PS_LSB +: 2];
		rs_code = rate_q[SBR_RS_LSB +: 3];
		pd_last = sbr_pd(ps_code) - 4'h1;
		bd_last = 7'((8'h01 << rs_code) - 8'h01);
		pre_d = pre_q;
		quad_d = quad_q;
		rdiv_d = rdiv_q;
		tick_d = 1'b0;
		if (pre_q >= pd_last) begin
			pre_d = 4'h0;
			quad_d = quad_q + 2'h1;
			if (quad_q == 2'(SBR_TICK_DIV - 1)) begin
				if (rdiv_q >= bd_last) begin
					rdiv_d = 7'h00;
					tick_d = 1'b1;
				end else begin
					rdiv_d = rdiv_q + 7'h01;
				end
			end
		end else begin
			pre_d = pre_q + 4'h1;
		end
		// Transmit bit tick shares the same 16x stream
		tkbit_d = tick_q ? tkbit_q + 4'h1 : tkbit_q;
		bit_d = tick_q && (tkbit_q == SBR_BIT_LAST);
	end

	// Receiver timing, stop sampling and wake logic
	always_comb begin
		nine = ctrl_q[SBR_CTL_NINE];
		st_d = st_q;
		ntick_d = ntick_q;
		bitn_d = bitn_q;
		shf_d = shf_q;
		smp_d = smp_q;
		idle_d = idle_q;
		line_hi_d = line_hi_q;
		rdata_d = rdata_q;
		ev_done = 1'b0;
		ev_frame = 1'b0;
		ev_woke = 1'b0;
		if (tick_q) begin
			ntick_d = ntick_q + 4'h1;
			if (ntick_q == SBR_BIT_LAST && rxd_s_q && idle_q != 5'(SBR_IDLE_BITS))
				idle_d = idle_q + 5'h01;
			if (!rxd_s_q)
				idle_d = 5'h00;
			// Line level at the previous tick, so a low stop bit cannot restart a frame
			line_hi_d = rxd_s_q;
			case (st_q)
				SBR_IDLE: begin
					if (!rxd_s_q && line_hi_q && ctrl_q[SBR_CTL_RXEN]) begin
						st_d = SBR_START;
						ntick_d = 4'h1;
					end
				end
				SBR_START: begin
					if (ntick_q == SBR_BIT_LAST) begin
						st_d = SBR_DATA;
						bitn_d = 4'h0;
					end
				end
				SBR_DATA: begin
					if (ntick_q == SBR_SMP_B)
						shf_d = {rxd_s_q, shf_q[DATA_W-1:1]};
					if (ntick_q == SBR_BIT_LAST) begin
						bitn_d = bitn_q + 4'h1;
						if (bitn_q == (nine ? 4'h8 : 4'h7))
							st_d = SBR_STOP;
					end
				end
				SBR_STOP: begin
					if (ntick_q == SBR_SMP_A)
						smp_d[0] = rxd_s_q;
					if (ntick_q == SBR_SMP_B)
						smp_d[1] = rxd_s_q;
					if (ntick_q == SBR_SMP_C) begin
						// Sampling done: 9 or 10 bits of 16 ticks plus 10 ticks
						st_d = SBR_IDLE;
						ev_done = 1'b1;
						ev_frame = !(smp_q[0] && smp_q[1] && rxd_s_q);
						rdata_d = nine ? shf_q : {1'b0, shf_q[DATA_W-1:1]};
					end
				end
				default: st_d = SBR_IDLE;
			endcase
		end
	end

	// Bus slave, status and interrupt
	always_comb begin
		logic [SBR_ST_W-1:0] ev;
		logic msb;
		ev = '0;
		msb = nine ? rdata_d[DATA_W-1] : rdata_d[DATA_W-2];
		rate_d = rate_q;
		ctrl_d = ctrl_q;
		stat_d = stat_q;
		mask_d = mask_q;
		hrdata_d = 32'h0000_0000;
		aph_wr_d = 1'b0;
		aph_rd_d = 1'b0;
		aph_addr_d = aph_addr_q;
		if (HSEL && HREADY && HTRANS == SBR_HTRANS_NONSEQ) begin
			aph_wr_d = HWRITE;
			aph_rd_d = !HWRITE;
			aph_addr_d = HADDR[7:0];
		end
		if (aph_wr_q) begin
			case (aph_addr_q)
				SBR_OFS_RATE: rate_d = {3'h0, HWDATA[4:0]};
				SBR_OFS_CTRL: ctrl_d = HWDATA[3:0];
				SBR_OFS_STAT: stat_d = stat_q & ~HWDATA[SBR_ST_W-1:0];
				SBR_OFS_MASK: mask_d = HWDATA[SBR_ST_W-1:0];
				default: mask_d = mask_q;
			endcase
		end
		// Standby exit by idle line or by character MSB
		if (ctrl_q[SBR_CTL_STANDBY]) begin
			if (ctrl_q[SBR_CTL_WAKE] ? (ev_done && msb) : (idle_q == 5'(SBR_IDLE_BITS))) begin
				ctrl_d[SBR_CTL_STANDBY] = 1'b0;
				ev[SBR_ST_WOKE] = 1'b1;
			end
		end
		// Receiver events dropped while in standby
		if (!ctrl_q[SBR_CTL_STANDBY] || !ctrl_d[SBR_CTL_STANDBY]) begin
			ev[SBR_ST_RXDONE] = ev_done && !ctrl_q[SBR_CTL_STANDBY];
			ev[SBR_ST_FRAME] = ev_frame && !ctrl_q[SBR_CTL_STANDBY];
		end
		// Set wins over a same-cycle clear
		stat_d = stat_d | ev;
		// In standby only the wake flag may raise the line
		irq_d = |(stat_d & mask_d);
		if (ctrl_d[SBR_CTL_STANDBY])
			irq_d = stat_d[SBR_ST_WOKE] && mask_d[SBR_ST_WOKE];
		// Read data from next-state values, so a write one cycle ahead is already seen
		if (aph_rd_d) begin
			case (aph_addr_d)
				SBR_OFS_RATE: hrdata_d = 32'(rate_d);
				SBR_OFS_CTRL: hrdata_d = 32'(ctrl_d);
				SBR_OFS_STAT: hrdata_d = 32'(stat_d);
				SBR_OFS_MASK: hrdata_d = 32'(mask_d);
				SBR_OFS_DATA: hrdata_d = 32'(rdata_d);
				default: hrdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			rate_q <= SBR_RATE_RST;
			ctrl_q <= 4'h0;
			stat_q <= '0;
			mask_q <= '0;
			rdata_q <= '0;
			hrdata_q <= 32'h0000_0000;
			aph_wr_q <= 1'b0;
			aph_rd_q <= 1'b0;
			aph_addr_q <= 8'h00;
			irq_q <= 1'b0;
			pre_q <= 4'h0;
			quad_q <= 2'h0;
			rdiv_q <= 7'h00;
			tick_q <= 1'b0;
			bit_q <= 1'b0;
			tkbit_q <= 4'h0;
			ntick_q <= 4'h0;
			st_q <= SBR_IDLE;
			bitn_q <= 4'h0;
			shf_q <= '0;
			smp_q <= 3'h0;
			idle_q <= 5'h00;
			line_hi_q <= 1'b1;
		end else begin
			rate_q <= rate_d;
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
			hrdata_q <= hrdata_d;
			aph_wr_q <= aph_wr_d;
			aph_rd_q <= aph_rd_d;
			aph_addr_q <= aph_addr_d;
			irq_q <= irq_d;
			pre_q <= pre_d;
			quad_q <= quad_d;
			rdiv_q <= rdiv_d;
			tick_q <= tick_d;
			bit_q <= bit_d;
			tkbit_q <= tkbit_d;
			ntick_q <= ntick_d;
			st_q <= st_d;
			bitn_q <= bitn_d;
			shf_q <= shf_d;
			smp_q <= smp_d;
			idle_q <= idle_d;
			line_hi_q <= line_hi_d;
		end
	end

	// Outputs straight from flops; zero wait states, always OKAY
	assign HRDATA = hrdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign TX_BIT_TICK = bit_q;
	assign RX_SAMPLE_TICK = tick_q;
	assign IRQ = irq_q;
endmodule

// file: sbr_line.sv
// Purpose: Remote transmitter on the receive line
// Assumes: Bit time given in MCLK cycles
// Notes: Line idles high outside frames
`timescale 1ns/100ps
module sbr_line (
	input wire logic MCLK,
	output logic RXD
);
	initial begin
		RXD = 1'b1;
	end
	// Start bit, data LSB first, then the stop level asked for
	task automatic send(input logic [8:0] d, input int nb, input int bt, input logic stp);
		for (int i = 0; i < nb + 2; i++) begin
			RXD <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i - 1];
			repeat (bt) @(posedge MCLK);
		end
		RXD <= 1'b1;
	endtask
endmodule

// file: sbr_core_props.sv
// Purpose: Port checks for the baud and receiver timing block
// Assumes: Zero wait bus, ticks are one-cycle pulses
// Notes: Bound to every core instance
`timescale 1ns/100ps
module sbr_core_props
	import sbr_pkg::*;
(
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HSEL,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic TX_BIT_TICK,
	input wire logic RX_SAMPLE_TICK,
	input wire logic IRQ
);
	logic [4:0] rt_q, rt_d;
	// Sample ticks seen since the last bit tick
	always_comb begin
		rt_d = (TX_BIT_TICK ? 5'h00 : rt_q) + {4'h0, RX_SAMPLE_TICK};
	end
	always_ff @(posedge MCLK) begin
		rt_q <= SRST ? 5'h00 : rt_d;
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	chk_ready_high: assert property (HREADYOUT) else $error("ready low");
	chk_resp_okay: assert property (!HRESP) else $error("resp not okay");
	chk_tick_pulse: assert property (RX_SAMPLE_TICK |=> !RX_SAMPLE_TICK [*3]) else $error("tick gap");
	chk_bit_ticks: assert property (TX_BIT_TICK |-> rt_q == 5'h10 || (rt_q == 5'h0F && RX_SAMPLE_TICK))
		else $error("ticks per bit");
	chk_bit_gap: assert property (TX_BIT_TICK |=> !TX_BIT_TICK [*8]) else $error("bit gap");
	chk_rdata_idle: assert property (!(HSEL && HREADY && !HWRITE && HTRANS == SBR_HTRANS_NONSEQ) |=> HRDATA == 32'h0)
		else $error("stray read data");
	chk_irq_reset: assert property ($fell(SRST) |-> !IRQ) else $error("irq after reset");
	chk_tick_reset: assert property ($fell(SRST) |-> !TX_BIT_TICK) else $error("tick after reset");
	cover property (TX_BIT_TICK);
	cover property ($rose(IRQ));
	cover property ($fell(IRQ));
endmodule
bind sbr_core sbr_core_props sbr_core_props_i (.MCLK(MCLK), .SRST(SRST), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HSEL(HSEL), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.TX_BIT_TICK(TX_BIT_TICK), .RX_SAMPLE_TICK(RX_SAMPLE_TICK), .IRQ(IRQ));

// file: sbr_core_tb.sv
// Purpose: Register and receive checks for the baud and receiver timing block
// Assumes: Rate zero gives 4 MCLK per tick, 64 per bit
// Notes: Frames come from the line model
`timescale 1ns/100ps
module sbr_core_tb;
	import sbr_pkg::*;
	logic mclk, srst, hwrite, hsel, hrdy, hresp, rxd, btk, rtk, irq;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0] pdv [4] = '{4'h1, 4'h3, 4'h4, 4'hD};
	int fails, checks_done, p, ps, rs;
	sbr_core sbr_core_i (.MCLK(mclk), .SRST(srst), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HSEL(hsel), .HREADY(hrdy), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
		.RXD(rxd), .TX_BIT_TICK(btk), .RX_SAMPLE_TICK(rtk), .IRQ(irq));
	sbr_line sbr_line_i (.MCLK(mclk), .RXD(rxd));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic finish_test();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	// One address phase, one data phase, each held until ready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= SBR_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			for (int n = 0; hrdy !== 1'b1; n++) begin
				if (n > 50) begin
					cmp("hready wait", 32'h1, 32'h0);
					finish_test();
				end
				@(posedge mclk);
			end
			// Address phase ends here; data phase is held until the second ready edge
			if (k == 0) begin
				htrans <= 2'h0;
				hsel <= 1'b0;
				hwdata <= d;
			end else begin
				rd = hrdata;
			end
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0);
		cmp("register", e, rd & m);
	endtask
	// Cycles between two pulses of the chosen tick; bounded so a dead tick ends
	task automatic measure(input logic sel);
		for (int k = 0; (sel ? btk : rtk) !== 1'b1 && k < 9000; k++) @(posedge mclk);
		p = 0;
		do begin
			@(posedge mclk);
			p++;
		end while ((sel ? btk : rtk) !== 1'b1 && p < 9000);
	endtask
	// Early status is read before the frame's own finish; a 9-bit one past the 8-bit point
	task automatic frame(input logic [8:0] d, input logic nine, input logic stp, input logic [31:0] st, input logic [31:0] m);
		fork
			sbr_line_i.send(d, nine ? 9 : 8, 64, stp);
			begin
				repeat (nine ? 640 : 560) @(posedge mclk);
				rdchk(SBR_OFS_STAT, 32'h0, 32'h7);
			end
		join
		repeat (20) @(posedge mclk);
		rdchk(SBR_OFS_STAT, st, m);
		cmp("irq", {31'h0, |st}, {31'h0, irq});
		bus(1'b1, SBR_OFS_STAT, 32'h7);
		repeat (3) @(posedge mclk);
		cmp("irq clear", 32'h0, {31'h0, irq});
	endtask
	initial begin
		repeat (100000) @(posedge mclk);
		cmp("timeout", 32'h0, 32'h1);
		finish_test();
	end
	initial begin
		srst = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		fails = 0;
		checks_done = 0;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rdchk(SBR_OFS_RATE, 32'h0, 32'hFF);
		rdchk(8'h20, 32'h0, 32'hFFFFFFFF);
		for (int i = 0; i < 12; i++) begin
			ps = (i < 4) ? i : 0;
			rs = (i < 4) ? 1 : i - 4;
			bus(1'b1, SBR_OFS_RATE, 32'(ps * 8 + rs));
			rdchk(SBR_OFS_RATE, 32'(ps * 8 + rs), 32'hFF);
			measure(1'b0);
			measure(1'b0);
			cmp("tick period", 32'(4 * pdv[ps] * (1 << rs)), 32'(p));
		end
		bus(1'b1, SBR_OFS_RATE, 32'h9);
		measure(1'b1);
		measure(1'b1);
		cmp("bit period", 32'd64 * 3 * 2, 32'(p));
		bus(1'b1, SBR_OFS_RATE, 32'h0);
		bus(1'b1, SBR_OFS_MASK, 32'h7);
		bus(1'b1, SBR_OFS_CTRL, 32'h8);
		frame(9'h0A5, 1'b0, 1'b1, 32'h1, 32'h3);
		rdchk(SBR_OFS_DATA, 32'hA5, 32'hFF);
		frame(9'h0C3, 1'b0, 1'b0, 32'h2, 32'h2);
		bus(1'b1, SBR_OFS_CTRL, 32'hC);
		frame(9'h1A5, 1'b1, 1'b1, 32'h1, 32'h3);
		rdchk(SBR_OFS_DATA, 32'h1A5, 32'h1FF);
		bus(1'b1, SBR_OFS_CTRL, 32'hB);
		frame(9'h035, 1'b0, 1'b1, 32'h0, 32'h7);
		rdchk(SBR_OFS_CTRL, 32'hB, 32'hF);
		frame(9'h0B5, 1'b0, 1'b1, 32'h4, 32'h4);
		rdchk(SBR_OFS_CTRL, 32'hA, 32'hF);
		bus(1'b1, SBR_OFS_CTRL, 32'h9);
		repeat (768) @(posedge mclk);
		rdchk(SBR_OFS_CTRL, 32'h8, 32'hF);
		rdchk(SBR_OFS_STAT, 32'h4, 32'h4);
		cmp("irq woke", 32'h1, {31'h0, irq});
		rdchk(SBR_OFS_MASK, 32'h7, 32'hFF);
		bus(1'b1, SBR_OFS_MASK, 32'h3);
		repeat (3) @(posedge mclk);
		cmp("irq masked", 32'h0, {31'h0, irq});
		finish_test();
	end
endmodule
